// File: hw/gpcg_defs.vh
// constants for the gpio pin configuration group
`ifndef GPCG_DEFS_VH
`define GPCG_DEFS_VH
// printed register indices (not all multiples of four: byte address = 4 * index)
`define GPCG_IDX_P37 8'h3a
`define GPCG_IDX_P40 8'h3b
`define GPCG_IDX_P41 8'h3c
`define GPCG_IDX_P42 8'h3d
`define GPCG_IDX_P43 8'h3e
`define GPCG_IDX_P50 8'h3f
`define GPCG_IDX_P51 8'h40
`define GPCG_IDX_P52 8'h41
// extra registers: pin data, event status, event mask, device-disable
`define GPCG_IDX_DATA 8'h50
`define GPCG_IDX_STAT 8'h51
`define GPCG_IDX_MASK 8'h52
`define GPCG_IDX_DDIS 8'h53
// field positions
`define GPCG_BIT_DIR 0
`define GPCG_BIT_POL 1
`define GPCG_BIT_ALT 2
`define GPCG_BIT_OD 7
// reset values
`define GPCG_CFG_RST 8'h01
`define GPCG_DDIS_RST 8'h00
// function codes
`define GPCG_FN_GPIO 2'b00
`define GPCG_FN_01 2'b01
`define GPCG_FN_10 2'b10
`define GPCG_FN_11 2'b11
// axi responses
`define GPCG_RESP_OKAY 2'b00
`define GPCG_RESP_SLVERR 2'b10
`endif

// File: hw/gpcg_sync.v
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
module gpcg_sync
(
  // clock and reset
  input wire core_clk_in,
  input wire reset_in,
  // async level in, synchronised level out
  input wire pin_in,
  output reg sync_out
);
  reg meta_q;

  // only the second flop reads meta_q
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: hw/gpcg_pin.v
// one pin's pad logic: direction, polarity, driver type
`timescale 1ns/1ps
module gpcg_pin
(
  // clock and reset
  input wire core_clk_in,
  input wire reset_in,
  // configuration
  input wire is_input_in,
  input wire invert_in,
  input wire open_drain_in,
  // value from the core, to be driven
  input wire core_val_in,
  // pad side
  input wire pad_in,
  output reg pad_out,
  output reg pad_oe_out,
  // value seen by the core, after polarity
  output wire core_val_out
);
  wire pad_sync;
  wire drv_val;

  gpcg_sync u_sync
  (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .pin_in(pad_in),
    .sync_out(pad_sync)
  );

  // polarity sits between pin and core in both directions
  assign core_val_out = pad_sync ^ invert_in;
  assign drv_val = core_val_in ^ invert_in;

  // open drain only pulls low; the oe releases for a one
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pad_out <= 1'b0;
      pad_oe_out <= 1'b0;
    end
    else
    begin
      pad_out <= drv_val;
      pad_oe_out <= ~is_input_in & (~open_drain_in | ~drv_val);
    end
  end
endmodule

// File: hw/gpcg_top.v
// gpio pin configuration group: registers, function muxing, axi4-lite slave
`timescale 1ns/1ps
`include "gpcg_defs.vh"
module gpcg_top
#(
  parameter NPIN = 8
)
(
  // clock and reset
  input wire core_clk_in,
  input wire reset_in,
  // axi4-lite write address and data
  input wire [31:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // axi4-lite read
  input wire [31:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // pads, index 0..7 = 3.7,4.0,4.1,4.2,4.3,5.0,5.1,5.2
  input wire [7:0] pad_in,
  output wire [7:0] pad_out,
  output wire [7:0] pad_oe_out,
  // alternate function sources driven by the core
  input wire gate_a20_mask_in,
  input wire drive_density_sel0_in,
  input wire drive_density_sel1_in,
  input wire power_event_in,
  // alternate function results
  output reg serial2_ring_indicate_n_out,
  output reg serial2_carrier_detect_n_out,
  output reg serial2_receive_in_out,
  output reg disable_reg_write_protect_out,
  output reg [7:0] device_disable_out,
  output reg irq_out
);
  // configuration registers, one per pin
  reg [7:0] cfg_q [0:7];
  reg [7:0] ddis_q;
  reg [7:0] dout_q;
  reg [1:0] stat_q;
  reg [1:0] mask_q;
  reg [1:0] edge_prev_q;
  // axi holding state
  reg aw_hold_q;
  reg w_hold_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire [7:0] core_in;
  wire [7:0] is_input;
  wire [7:0] invert;
  wire [7:0] drive_val;
  wire protect_on;
  wire [1:0] fn41;
  wire [1:0] fn43;
  wire [1:0] fn50;
  wire [1:0] fn51;
  wire [1:0] fn52;
  wire [1:0] edge_lvl;
  wire [1:0] edge_hit;

  assign fn41 = cfg_q[2][3:2];
  assign fn43 = cfg_q[4][3:2];
  assign fn50 = cfg_q[5][3:2];
  assign fn51 = cfg_q[6][3:2];
  assign fn52 = cfg_q[7][3:2];
  // protect is code 01 on pin 4.3; the write lock below keeps it until reset
  assign protect_on = (fn43 == `GPCG_FN_01);

  // direction and polarity per pin; pin 4.3 forced under protect
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_pin
      if (gi == 4)
      begin : g_p43
        assign is_input[gi] = cfg_q[gi][`GPCG_BIT_DIR] | protect_on;
        assign invert[gi] = cfg_q[gi][`GPCG_BIT_POL] & ~protect_on;
      end
      else
      begin : g_pn
        assign is_input[gi] = cfg_q[gi][`GPCG_BIT_DIR];
        assign invert[gi] = cfg_q[gi][`GPCG_BIT_POL];
      end
      gpcg_pin u_pin
      (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .is_input_in(is_input[gi]),
        .invert_in(invert[gi]),
        .open_drain_in(cfg_q[gi][`GPCG_BIT_OD]),
        .core_val_in(drive_val[gi]),
        .pad_in(pad_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe_out(pad_oe_out[gi]),
        .core_val_out(core_in[gi])
      );
    end
  endgenerate

  // output value mux: alternate sources replace the data register bit
  // the pin module applies the polarity bit after this mux
  assign drive_val[0] = cfg_q[0][`GPCG_BIT_ALT] ? gate_a20_mask_in : dout_q[0];
  assign drive_val[1] = cfg_q[1][`GPCG_BIT_ALT] ? drive_density_sel0_in : dout_q[1];
  // reserved code 11 falls back to the data bit
  assign drive_val[2] = (fn41 == `GPCG_FN_01) ? drive_density_sel1_in : dout_q[2];
  // power event is low when active; polarity bit zero leaves it active low
  assign drive_val[3] = cfg_q[3][`GPCG_BIT_ALT] ? ~power_event_in : dout_q[3];
  assign drive_val[7:4] = dout_q[7:4];

  // either-edge inputs 2 and 4 watch the pin level after polarity
  assign edge_lvl[0] = core_in[2];
  assign edge_lvl[1] = core_in[4];
  // history runs even while the function is off, so selecting the function
  // on a pin that sits high is not taken for an edge; it resets to zero
  // like the synchroniser, so reset gives no edge either
  assign edge_hit = {(fn43 == `GPCG_FN_11), (fn41 == `GPCG_FN_10)} & (edge_lvl ^ edge_prev_q);

  // axi decode helpers: a channel counts as present while held or while live,
  // so address and data may arrive in either order; no write fires while a
  // response still waits for bready, which keeps one write in flight
  wire aw_ok;
  wire w_ok;
  wire do_write;
  wire [29:0] wr_idx;
  wire [7:0] wb;
  assign aw_ok = aw_hold_q | s_axi_awvalid_in;
  assign w_ok = w_hold_q | s_axi_wvalid_in;
  assign do_write = aw_ok & w_ok & ~s_axi_bvalid_out;
  assign wr_idx = aw_hold_q ? awaddr_q[31:2] : s_axi_awaddr_in[31:2];
  assign wb = w_hold_q ? wdata_q[7:0] : s_axi_wdata_in[7:0];
  // only byte lane 0 carries data; a cleared strobe gets OKAY on a mapped index and changes nothing
  wire strb0;
  assign strb0 = w_hold_q ? wstrb_q[0] : s_axi_wstrb_in[0];
  wire wr_en;
  assign wr_en = do_write & strb0;

  // mapped index test
  // unmapped addresses answer SLVERR and have no effect
  function is_mapped;
    input [29:0] idx;
    begin
      is_mapped = ((idx >= {22'h0, `GPCG_IDX_P37}) && (idx <= {22'h0, `GPCG_IDX_P52})) ||
                  ((idx >= {22'h0, `GPCG_IDX_DATA}) && (idx <= {22'h0, `GPCG_IDX_DDIS}));
    end
  endfunction

  // masked write value: reserved bits kept at zero
  // pins 3.7, 4.0 and 4.2 (slots 0, 1, 3) have a single select bit
  function [7:0] cfg_mask;
    input [2:0] pin;
    begin
      if (pin <= 3'd1 || pin == 3'd3)
        cfg_mask = 8'h87;
      else
        cfg_mask = 8'h8f;
    end
  endfunction

  // write channel and register update
  integer i;
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      for (i = 0; i < 8; i = i + 1)
        cfg_q[i] <= `GPCG_CFG_RST;
      ddis_q <= `GPCG_DDIS_RST;
      dout_q <= 8'h00;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      edge_prev_q <= 2'h0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `GPCG_RESP_OKAY;
    end
    else
    begin
      edge_prev_q <= edge_lvl;
      // hold each channel once taken; ready drops until the response
      if (s_axi_awvalid_in && s_axi_awready_out && !do_write)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out && !do_write)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= is_mapped(wr_idx) ? `GPCG_RESP_OKAY : `GPCG_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
      // register writes through byte lane 0
      // index 0x3a maps to slot 0: the low three index bits minus two give the slot
      if (wr_en && wr_idx >= {22'h0, `GPCG_IDX_P37} && wr_idx <= {22'h0, `GPCG_IDX_P52})
      begin
        // under protect only the direction, polarity and driver bits of 4.3 change
        if (wr_idx[2:0] == 3'd6 && protect_on)
          cfg_q[4] <= {wb[7:4] & 4'h8, `GPCG_FN_01, wb[1:0]};
        else
          cfg_q[wr_idx[2:0] - 3'd2] <= wb & cfg_mask(wr_idx[2:0] - 3'd2);
      end
      if (wr_en && wr_idx == {22'h0, `GPCG_IDX_DATA})
        dout_q <= wb;
      if (wr_en && wr_idx == {22'h0, `GPCG_IDX_MASK})
        mask_q <= wb[1:0];
      // pin high under protect locks the register; low lets writes through
      if (wr_en && wr_idx == {22'h0, `GPCG_IDX_DDIS} && !(protect_on && core_in[4]))
        ddis_q <= wb;
      // set beats a same-cycle write-one-to-clear
      if (wr_en && wr_idx == {22'h0, `GPCG_IDX_STAT})
        stat_q <= (stat_q & ~wb[1:0]) | edge_hit;
      else
        stat_q <= stat_q | edge_hit;
    end
  end

  // read data mux
  reg [7:0] rd_val;
  always @*
  begin
    rd_val = 8'h00;
    case (s_axi_araddr_in[9:2])
      `GPCG_IDX_P37: rd_val = cfg_q[0];
      `GPCG_IDX_P40: rd_val = cfg_q[1];
      `GPCG_IDX_P41: rd_val = cfg_q[2];
      `GPCG_IDX_P42: rd_val = cfg_q[3];
      `GPCG_IDX_P43: rd_val = cfg_q[4];
      `GPCG_IDX_P50: rd_val = cfg_q[5];
      `GPCG_IDX_P51: rd_val = cfg_q[6];
      `GPCG_IDX_P52: rd_val = cfg_q[7];
      `GPCG_IDX_DATA: rd_val = core_in;
      `GPCG_IDX_STAT: rd_val = {6'h0, stat_q};
      `GPCG_IDX_MASK: rd_val = {6'h0, mask_q};
      `GPCG_IDX_DDIS: rd_val = ddis_q;
      default: rd_val = 8'h00;
    endcase
  end

  // read channel: one-cycle answer, held until rready
  // data comes from the live address in the cycle of the address handshake;
  // the mux decodes address bits 9:2, so anything above bit 9 gets SLVERR
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= `GPCG_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h0, rd_val};
      s_axi_rresp_out <= (is_mapped(s_axi_araddr_in[31:2]) && s_axi_araddr_in[31:10] == 22'h0) ?
                         `GPCG_RESP_OKAY : `GPCG_RESP_SLVERR;
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // serial port 2 routing; reserved codes give idle levels
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      serial2_ring_indicate_n_out <= 1'b1;
      serial2_carrier_detect_n_out <= 1'b1;
      serial2_receive_in_out <= 1'b1;
      disable_reg_write_protect_out <= 1'b0;
      device_disable_out <= `GPCG_DDIS_RST;
      irq_out <= 1'b0;
    end
    else
    begin
      serial2_ring_indicate_n_out <= (fn50 == `GPCG_FN_01) ? core_in[5] : 1'b1;
      serial2_carrier_detect_n_out <= (fn51 == `GPCG_FN_01) ? core_in[6] : 1'b1;
      serial2_receive_in_out <= (fn52 == `GPCG_FN_01) ? core_in[7] : 1'b1;
      // lock mirrors the write gate: protect selected and pin 4.3 high
      disable_reg_write_protect_out <= protect_on & core_in[4];
      device_disable_out <= ddis_q;
      // level interrupt: stays up until software clears the status or the mask
      irq_out <= |(stat_q & mask_q);
    end
  end
endmodule

// File: verification/gpcg_monitor.sv
// assertion monitor for the gpio pin configuration group
`timescale 1ns/1ps
module gpcg_monitor
(
  // clock and reset
  input wire core_clk_in,
  input wire reset_in,
  // pads and bus handshakes
  input wire [7:0] pad_in,
  input wire [7:0] pad_oe_out,
  input wire s_axi_awvalid_in,
  input wire s_axi_wvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  // alternate function results
  input wire serial2_ring_indicate_n_out,
  input wire serial2_carrier_detect_n_out,
  input wire serial2_receive_in_out,
  input wire disable_reg_write_protect_out,
  input wire [7:0] device_disable_out,
  input wire irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // pin 4.3 low long enough to cross the synchroniser
  sequence s_pin43_low;
    !pad_in[4] [*5];
  endsequence
  // lock seen on three edges running
  sequence s_locked;
    disable_reg_write_protect_out [*3];
  endsequence
  property p_rst;
    $fell(reset_in) |-> pad_oe_out == 8'h00 && !irq_out && !disable_reg_write_protect_out &&
      serial2_ring_indicate_n_out && serial2_carrier_detect_n_out && serial2_receive_in_out;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  // lock may only come from a high pin, seen through two sync flops
  property p_lock_rise;
    $rose(disable_reg_write_protect_out) |-> $past(pad_in[4], 2) || $past(pad_in[4], 3) || $past(pad_in[4], 4);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock without high pin");
  property p_unlock;
    s_pin43_low |=> !disable_reg_write_protect_out;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock while pin low");
  property p_lock_input;
    disable_reg_write_protect_out |-> !pad_oe_out[4];
  endproperty
  a_lock_input: assert property (p_lock_input) else $error("protect pin driven");
  property p_ddis_hold;
    s_locked |-> $stable(device_disable_out);
  endproperty
  a_ddis_hold: assert property (p_ddis_hold) else $error("disable register changed while locked");
  property p_aw_wait;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_aw_wait: assert property (p_aw_wait) else $error("write ready during response");
  property p_r_wait;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_r_wait: assert property (p_r_wait) else $error("read ready during response");
  property p_b_cause;
    $rose(s_axi_bvalid_out) |-> $past(s_axi_awvalid_in || s_axi_wvalid_in);
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("response without request");
endmodule

bind gpcg_top gpcg_monitor i_gpcg_monitor
(
  .core_clk_in(core_clk_in), .reset_in(reset_in), .pad_in(pad_in), .pad_oe_out(pad_oe_out),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .serial2_ring_indicate_n_out(serial2_ring_indicate_n_out),
  .serial2_carrier_detect_n_out(serial2_carrier_detect_n_out), .serial2_receive_in_out(serial2_receive_in_out),
  .disable_reg_write_protect_out(disable_reg_write_protect_out), .device_disable_out(device_disable_out),
  .irq_out(irq_out)
);

// File: verification/gpcg_top_tb_top.sv
// self-checking testbench for the gpio pin configuration group
`timescale 1ns/1ps
`include "gpcg_defs.vh"
module gpcg_top_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, lfsr = 32'hd999, v;
  reg awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  reg [7:0] pad = 8'hff;
  reg [3:0] src = 4'h0, strb = 4'h1;
  reg [7:0] i, k, d, e;
  reg [1:0] resp;
  reg p;
  wire awr, wr, bv, arr, rv, irq, lock, ri, dcd, rxd;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pout, poe, ddis;
  integer n_mismatch = 0, check_count = 0, cyc = 0;
  gpcg_top i_gpcg_top
  (
    .core_clk_in(clk), .reset_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
    .pad_in(pad), .pad_out(pout), .pad_oe_out(poe),
    .gate_a20_mask_in(src[0]), .drive_density_sel0_in(src[1]), .drive_density_sel1_in(src[2]),
    .power_event_in(src[3]), .serial2_ring_indicate_n_out(ri), .serial2_carrier_detect_n_out(dcd),
    .serial2_receive_in_out(rxd), .disable_reg_write_protect_out(lock), .device_disable_out(ddis),
    .irq_out(irq)
  );
  // 200 mhz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // hang guard, far above the expected few hundred cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // writable bits: single-bit select pins keep 6:3 reserved, the others 6:4
  function [7:0] cmask(input [7:0] n);
    cmask = (n == 0 || n == 1 || n == 3) ? 8'h87 : 8'h8f;
  endfunction
  task conclude;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // address and data offered together, each released once taken
  task axw(input [7:0] a, input [7:0] dv, output [1:0] r);
    begin
      @(posedge clk);
      awaddr <= {22'h0, a, 2'b00};
      wdata <= {24'h0, dv};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wr) wv <= 1'b0;
      end
      while (!bv);
      r = bresp;
      bready <= 1'b0;
    end
  endtask
  task axr(input [7:0] a, output [31:0] dv, output [1:0] r);
    begin
      @(posedge clk);
      araddr <= {22'h0, a, 2'b00};
      arv <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
      end
      while (!rv);
      dv = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask
  task wrc(input [7:0] a, input [7:0] dv);
    begin
      axw(a, dv, resp);
      chk(resp, `GPCG_RESP_OKAY);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      axr(a, v, resp);
      chk(v, exp);
      chk(resp, `GPCG_RESP_OKAY);
    end
  endtask
  // main sequence
  initial
  begin
    tick(20);
    rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) rdc(8'h3a + i, 32'h01);
    chk(poe, 8'h00);
    // random patterns; pin 4.3 avoids code 01 so it stays unlocked here
    for (k = 0; k < 24; k = k + 1)
    begin
      lfsr = nxt(lfsr);
      i = k % 8;
      d = lfsr[7:0];
      if (i == 4 && d[3:2] == 2'b01) d[3] = 1'b1;
      wrc(8'h3a + i, d);
      rdc(8'h3a + i, d & cmask(i));
    end
    // pin 4.0 as output, k = {open drain, invert, value}
    for (k = 0; k < 8; k = k + 1)
    begin
      wrc(8'h3b, {k[2], 5'h0, k[1], 1'b0});
      wrc(`GPCG_IDX_DATA, {6'h0, k[0], 1'b0});
      tick(2);
      p = k[0] ^ k[1];
      chk(poe[1], k[2] ? !p : 1'b1);
      if (poe[1] === 1'b1) chk(pout[1], p);
    end
    // pin 4.0 as input against random pad levels
    for (k = 0; k < 4; k = k + 1)
    begin
      lfsr = nxt(lfsr);
      wrc(8'h3b, {6'h0, k[0], 1'b1});
      pad <= lfsr[7:0];
      tick(3);
      axr(`GPCG_IDX_DATA, v, resp);
      chk(v[1], lfsr[1] ^ k[0]);
    end
    // one source low and the rest high, then one high and the rest low, so a wrong route shows
    for (k = 0; k < 8; k = k + 1)
    begin
      i = k / 2;
      wrc(8'h3a + i, 8'h04);
      src <= k[0] ? (4'h1 << i) : ~(4'h1 << i);
      tick(3);
      chk(pout[i], k[0] ^ (i == 3));
      chk(poe[i], 1'b1);
    end
    // reserved code 11 on pin 4.1 keeps the data bit, not the density source
    wrc(8'h3c, 8'h0c);
    wrc(`GPCG_IDX_DATA, 8'h00);
    src <= 4'hf;
    tick(3);
    chk(pout[2], 1'b0);
    for (i = 5; i < 8; i = i + 1)
    begin
      wrc(8'h3a + i, 8'h05);
      pad <= 8'hff ^ (8'h01 << i);
      tick(5);
      chk({rxd, dcd, ri}, 3'h7 ^ (3'h1 << (i - 5)));
      wrc(8'h3a + i, 8'h09);
      tick(5);
      chk({rxd, dcd, ri}, 3'h7);
    end
    // edge interrupts on 4.1 and 4.3: masked, fall, clear, rise
    for (k = 0; k < 2; k = k + 1)
    begin
      i = k ? 8'd4 : 8'd2;
      e = k ? 8'h02 : 8'h01;
      pad <= 8'hff;
      wrc(8'h3a + i, k ? 8'h0d : 8'h09);
      wrc(`GPCG_IDX_STAT, 8'h03);
      pad <= 8'hff ^ (8'h01 << i);
      tick(5);
      chk(irq, 1'b0);
      rdc(`GPCG_IDX_STAT, e);
      wrc(`GPCG_IDX_MASK, e);
      tick(2);
      chk(irq, 1'b1);
      wrc(`GPCG_IDX_STAT, e);
      tick(2);
      chk(irq, 1'b0);
      pad <= 8'hff;
      tick(5);
      chk(irq, 1'b1);
      wrc(`GPCG_IDX_STAT, e);
      wrc(`GPCG_IDX_MASK, 8'h00);
    end
    // byte lane 0 disabled: the write is answered but lands nowhere
    strb <= 4'h0;
    wrc(`GPCG_IDX_MASK, 8'h03);
    strb <= 4'h1;
    rdc(`GPCG_IDX_MASK, 32'h00);
    // protect on 4.3 written as an inverted output: must still act as plain input
    wrc(8'h3e, 8'h06);
    tick(4);
    chk(lock, 1'b1);
    chk(poe[4], 1'b0);
    axr(`GPCG_IDX_DATA, v, resp);
    chk(v[4], 1'b1);
    wrc(8'h3e, 8'h82);
    rdc(8'h3e, 8'h86);
    wrc(`GPCG_IDX_DDIS, 8'h5a);
    rdc(`GPCG_IDX_DDIS, 8'h00);
    pad <= 8'hef;
    tick(4);
    chk(lock, 1'b0);
    axr(`GPCG_IDX_DATA, v, resp);
    chk(v[4], 1'b0);
    wrc(`GPCG_IDX_DDIS, 8'h5a);
    rdc(`GPCG_IDX_DDIS, 8'h5a);
    chk(ddis, 8'h5a);
    axr(8'h60, v, resp);
    chk(resp, `GPCG_RESP_SLVERR);
    // second reset in mid-run clears the locked field
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rdc(8'h3e, 8'h01);
    chk(lock, 1'b0);
    conclude;
  end
endmodule
